// ### hdl/tmr_clk_pkg.sv
// Constants, field layouts and types for the dual timer count control.
// Assumes one peripheral clock domain; fast-clock ticks arrive as enables.
package tmr_clk_pkg;
	localparam logic [15:0] T0_CTRL_ADDR = 16'hff7e;
	localparam logic [15:0] T1_CTRL_ADDR = 16'hff94;
	localparam int RUN_BIT = 7;
	localparam int CS_MSB = 2;
	localparam int CS_W = 3;
	localparam logic [7:0] CTRL_MASK = 8'h87;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int PLL_SEL_BIT = 3;
	localparam int MODE_MSB = 1;
	localparam int MODE_LSB = 0;
	localparam int PRE_W = 7;
	localparam int TICK_N = 8;
	localparam int CNT_W = 16;
	localparam logic [CS_W-1:0] CS_FAST = 3'h0;
	localparam logic [CS_W-1:0] CS_UNDIV = 3'h1;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	typedef enum logic [1:0] {
		mode_alone,
		mode_sync_start,
		mode_sync_clear,
		mode_bad
	} timer1_mode_t;
endpackage

// ### hdl/prescale_if.sv
// Carrier for prescaler tick enables between prescaler and control logic.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface prescale_if;
	logic [tmr_clk_pkg::TICK_N-1:0] tick;
	modport src (output tick);
	modport snk (input tick);
endinterface

// ### hdl/tick_prescaler.sv
// Free-running prescaler producing one-cycle tick enables for /1 to /128.
// Assumes synchronous clock and the synchronised reset from the top.
`timescale 1ns/100ps
module tick_prescaler (
	input wire logic clk_i,
	input wire logic rst_n_i,
	prescale_if.src pre
);
	logic [tmr_clk_pkg::PRE_W-1:0] cnt_q;
	logic [tmr_clk_pkg::PRE_W-1:0] cnt_d;
	logic [tmr_clk_pkg::TICK_N-1:0] tick_q;
	logic [tmr_clk_pkg::TICK_N-1:0] tick_d;
	logic [tmr_clk_pkg::PRE_W-1:0] mask;

	// Tick k fires once every 2^k cycles
	always_comb begin
		mask = '0;
		cnt_d = cnt_q + tmr_clk_pkg::PRE_W'(1);
		for (int k = 0; k < tmr_clk_pkg::TICK_N; k++) begin
			mask = tmr_clk_pkg::PRE_W'((1 << k) - 1);
			tick_d[k] = ((cnt_q & mask) == mask);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= '0;
			tick_q <= '0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign pre.tick = tick_q;
endmodule

// ### hdl/timer_count_clock_control.sv
// Count control registers, count clock selection and counters of two timers.
// Assumes CPU accesses, PLL control and mode bits come from clk_i logic.
`timescale 1ns/100ps
module timer_count_clock_control (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [15:0] cpu_addr_i,
	input wire logic cpu_wr_i,
	input wire logic [7:0] cpu_wdata_i,
	input wire logic cpu_bit_wr_i,
	input wire logic [2:0] cpu_bit_sel_i,
	input wire logic cpu_bit_val_i,
	input wire logic cpu_rd_i,
	output logic [7:0] cpu_rdata_o,
	input wire logic [7:0] osc_pll_control_reg_i,
	input wire logic [7:0] timer1_ctrl1_i,
	input wire logic fast_timer_clock_tick_i,
	output logic [15:0] timer0_count_o,
	output logic [15:0] timer1_count_o,
	output logic timer0_tick_o,
	output logic timer1_tick_o
);
	logic rst_s1_q;
	logic rst_s1_d;
	logic rst_n_q;
	logic rst_n_d;
	logic [7:0] ctrl0_q;
	logic [7:0] ctrl0_d;
	logic [7:0] ctrl1_q;
	logic [7:0] ctrl1_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [15:0] cnt0_q;
	logic [15:0] cnt0_d;
	logic [15:0] cnt1_q;
	logic [15:0] cnt1_d;
	logic tick0_q;
	logic tick0_d;
	logic tick1_q;
	logic tick1_d;
	logic hit0;
	logic hit1;
	logic pll_select;
	logic run0;
	logic own_run1;
	logic run1;
	logic [2:0] cs0;
	logic [2:0] cs1;
	logic sel0;
	logic own_sel1;
	logic sel1;
	tmr_clk_pkg::timer1_mode_t mode;

	prescale_if pre ();

	tick_prescaler u_pre (
		.clk_i(clk_i),
		.rst_n_i(rst_n_q),
		.pre(pre)
	);

	// Reset release synchroniser
	always_comb begin
		rst_s1_d = 1'b1;
		rst_n_d = rst_s1_q;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= rst_s1_d;
			rst_n_q <= rst_n_d;
		end
	end

	// Address decode for one register
	function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] base);
		logic h;
		h = (addr == base);
		return h;
	endfunction

	// Run bit of a count control value
	function automatic logic run_bit(input logic [7:0] ctrl);
		logic r;
		r = ctrl[tmr_clk_pkg::RUN_BIT];
		return r;
	endfunction

	// Clock-select field of a count control value
	function automatic logic [2:0] cs_field(input logic [7:0] ctrl);
		logic [2:0] c;
		c = ctrl[tmr_clk_pkg::CS_MSB:0];
		return c;
	endfunction

	// Byte or single-bit write, masked to the implemented bits
	function automatic logic [7:0] reg_write(input logic [7:0] cur, input logic wr,
			input logic [7:0] wdata, input logic bwr, input logic [2:0] bsel,
			input logic bval);
		logic [7:0] v;
		v = cur;
		if (wr) begin
			v = wdata;
		end else if (bwr) begin
			v[bsel] = bval;
		end
		return v & tmr_clk_pkg::CTRL_MASK;
	endfunction

	// Tick enable for one clock-select setting
	function automatic logic pick_tick(input logic pll, input logic [2:0] cs,
			input logic [7:0] ticks, input logic fast);
		logic t;
		t = 1'b0;
		if (!pll) begin
			t = ticks[cs];
		end else begin
			case (cs)
				tmr_clk_pkg::CS_FAST: begin
					t = fast;
				end
				tmr_clk_pkg::CS_UNDIV: begin
					t = ticks[0];
				end
				default: begin
					t = 1'b0;
				end
			endcase
		end
		return t;
	endfunction

	// Next counter value: cleared while stopped, one up per tick
	function automatic logic [15:0] next_count(input logic run, input logic step,
			input logic [15:0] cur);
		logic [15:0] n;
		n = cur;
		if (!run) begin
			n = tmr_clk_pkg::CNT_ZERO;
		end else if (step) begin
			n = cur + tmr_clk_pkg::CNT_ONE;
		end
		return n;
	endfunction

	// Address decode shared by writes and reads
	always_comb begin
		hit0 = addr_hit(cpu_addr_i, tmr_clk_pkg::T0_CTRL_ADDR);
		hit1 = addr_hit(cpu_addr_i, tmr_clk_pkg::T1_CTRL_ADDR);
	end

	// First timer count control register
	always_comb begin
		ctrl0_d = ctrl0_q;
		if (hit0) begin
			ctrl0_d = reg_write(ctrl0_q, cpu_wr_i, cpu_wdata_i, cpu_bit_wr_i,
				cpu_bit_sel_i, cpu_bit_val_i);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl0_q <= tmr_clk_pkg::CTRL_RESET;
		end else begin
			ctrl0_q <= ctrl0_d;
		end
	end

	// Second timer count control register
	always_comb begin
		ctrl1_d = ctrl1_q;
		if (hit1) begin
			ctrl1_d = reg_write(ctrl1_q, cpu_wr_i, cpu_wdata_i, cpu_bit_wr_i,
				cpu_bit_sel_i, cpu_bit_val_i);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl1_q <= tmr_clk_pkg::CTRL_RESET;
		end else begin
			ctrl1_q <= ctrl1_d;
		end
	end

	// Read data register, holds until the next read
	always_comb begin
		rdata_d = rdata_q;
		if (cpu_rd_i) begin
			if (hit0) begin
				rdata_d = ctrl0_q;
			end else if (hit1) begin
				rdata_d = ctrl1_q;
			end else begin
				rdata_d = '0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Live PLL select, second timer mode and control fields
	always_comb begin
		pll_select = osc_pll_control_reg_i[tmr_clk_pkg::PLL_SEL_BIT];
		mode = tmr_clk_pkg::timer1_mode_t'(
			timer1_ctrl1_i[tmr_clk_pkg::MODE_MSB:tmr_clk_pkg::MODE_LSB]);
		run0 = run_bit(ctrl0_q);
		own_run1 = run_bit(ctrl1_q);
		cs0 = cs_field(ctrl0_q);
		cs1 = cs_field(ctrl1_q);
	end

	// Count tick selection and second timer run control
	always_comb begin
		sel0 = pick_tick(pll_select, cs0, pre.tick, fast_timer_clock_tick_i);
		own_sel1 = pick_tick(pll_select, cs1, pre.tick, fast_timer_clock_tick_i);
		// Clock-select can be written while running; all choices are clk_i enables, so no glitch guard here
		case (mode)
			tmr_clk_pkg::mode_alone: begin
				run1 = own_run1;
				sel1 = own_sel1;
			end
			tmr_clk_pkg::mode_sync_start: begin
				run1 = own_run1 & run0;
				sel1 = own_sel1;
			end
			tmr_clk_pkg::mode_sync_clear: begin
				run1 = run0;
				sel1 = sel0;
			end
			default: begin
				run1 = 1'b0;
				sel1 = 1'b0;
			end
		endcase
	end

	// Registered copy of the first timer's count enable
	always_comb begin
		tick0_d = run0 & sel0;
	end

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tick0_q <= 1'b0;
		end else begin
			tick0_q <= tick0_d;
		end
	end

	// Registered copy of the second timer's count enable
	always_comb begin
		tick1_d = run1 & sel1;
	end

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tick1_q <= 1'b0;
		end else begin
			tick1_q <= tick1_d;
		end
	end

	// First timer counter
	always_comb begin
		cnt0_d = next_count(run0, sel0, cnt0_q);
	end

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cnt0_q <= tmr_clk_pkg::CNT_ZERO;
		end else begin
			cnt0_q <= cnt0_d;
		end
	end

	// Second timer counter
	always_comb begin
		cnt1_d = next_count(run1, sel1, cnt1_q);
	end

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cnt1_q <= tmr_clk_pkg::CNT_ZERO;
		end else begin
			cnt1_q <= cnt1_d;
		end
	end

	// Outputs straight from registers
	assign cpu_rdata_o = rdata_q;
	assign timer0_count_o = cnt0_q;
	assign timer1_count_o = cnt1_q;
	assign timer0_tick_o = tick0_q;
	assign timer1_tick_o = tick1_q;
endmodule

// ### verif/tcc_assertions.sv
// Checker of run control, clock choice and register reads.
// Bound to the top module; sees its ports only.
`timescale 1ns/100ps
module tcc_chk (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [15:0] cpu_addr_i,
	input wire logic cpu_wr_i,
	input wire logic [7:0] cpu_wdata_i,
	input wire logic cpu_rd_i,
	input wire logic [7:0] cpu_rdata_o,
	input wire logic [7:0] osc_pll_control_reg_i,
	input wire logic [7:0] timer1_ctrl1_i,
	input wire logic [15:0] timer0_count_o,
	input wire logic [15:0] timer1_count_o,
	input wire logic timer0_tick_o,
	input wire logic timer1_tick_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	wire [1:0] md = timer1_ctrl1_i[1:0];
	wire wr0 = cpu_wr_i && cpu_addr_i == 16'hff7e;
	wire wr1 = cpu_wr_i && cpu_addr_i == 16'hff94;
	wire pll = osc_pll_control_reg_i[3];
	sequence s_bad_sel;
		wr0 && cpu_wdata_i == 8'h82 && pll ##1 (!wr0 && pll) [*4];
	endsequence
	a_stop_zero0: assert property (wr0 && !cpu_wdata_i[7] |-> ##2 timer0_count_o == 16'h0000)
		else $error("timer0 not cleared");
	a_stop_zero1: assert property (wr1 && !cpu_wdata_i[7] && md == 2'h0 |-> ##2 !timer1_count_o)
		else $error("timer1 not cleared");
	a_count_step: assert property (timer0_count_o != $past(timer0_count_o) |->
		timer0_count_o == $past(timer0_count_o) + 16'h0001 || timer0_count_o == 16'h0000)
		else $error("timer0 jumped");
	a_tick_step: assert property (timer0_count_o != $past(timer0_count_o) && timer0_count_o != 16'h0000
		|-> ##[0:1] timer0_tick_o) else $error("step without tick");
	a_bad_select: assert property (s_bad_sel |-> !timer0_tick_o)
		else $error("prohibited select ticks");
	a_sync_clear: assert property (md == 2'h2 && $past(md) == 2'h2 |-> timer1_tick_o == timer0_tick_o)
		else $error("timer1 not on timer0 tick");
	a_mode_bad: assert property ($past(md) == 2'h3 |-> timer1_count_o == 16'h0000)
		else $error("timer1 counts in mode 3");
	a_rsvd_zero: assert property (cpu_rd_i |=> (cpu_rdata_o & 8'h78) == 8'h00)
		else $error("reserved bits set");
endmodule
bind timer_count_clock_control tcc_chk i_tcc_chk (.clk_i(clk_i), .nrst_i(nrst_i),
	.cpu_addr_i(cpu_addr_i), .cpu_wr_i(cpu_wr_i), .cpu_wdata_i(cpu_wdata_i), .cpu_rd_i(cpu_rd_i),
	.cpu_rdata_o(cpu_rdata_o), .osc_pll_control_reg_i(osc_pll_control_reg_i),
	.timer1_ctrl1_i(timer1_ctrl1_i), .timer0_count_o(timer0_count_o),
	.timer1_count_o(timer1_count_o), .timer0_tick_o(timer0_tick_o), .timer1_tick_o(timer1_tick_o));

// ### verif/tb_timer_count_clock_control.sv
// Self-checking bench for the dual timer count control.
// Drives the top ports directly; no partner model.
`timescale 1ns/100ps
module tb_timer_count_clock_control;
	logic clk_i = 1'b0, nrst_i = 1'b0, wr = 1'b0, bwr = 1'b0, bval = 1'b0, rd = 1'b0, fast = 1'b0;
	logic [15:0] addr = 16'h0000, cnt0, cnt1;
	logic [7:0] wd = 8'h00, osc = 8'h00, c1 = 8'h00, rdat;
	logic [2:0] bsel = 3'h0;
	logic tk0, tk1;
	int n_fail = 0, num_checks = 0;
	timer_count_clock_control i_timer_count_clock_control (.clk_i(clk_i), .nrst_i(nrst_i),
		.cpu_addr_i(addr), .cpu_wr_i(wr), .cpu_wdata_i(wd), .cpu_bit_wr_i(bwr),
		.cpu_bit_sel_i(bsel), .cpu_bit_val_i(bval), .cpu_rd_i(rd), .cpu_rdata_o(rdat),
		.osc_pll_control_reg_i(osc), .timer1_ctrl1_i(c1), .fast_timer_clock_tick_i(fast),
		.timer0_count_o(cnt0), .timer1_count_o(cnt1), .timer0_tick_o(tk0), .timer1_tick_o(tk1));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) fast <= ~fast;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		if (n_fail == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Kind: 1 byte write, 2 bit write (index d[2:0], value d[3]), 4 read
	task automatic op(input logic [15:0] a, input logic [7:0] d, input logic [2:0] k);
		@(posedge clk_i);
		{addr, wd, bsel, bval} <= {a, d, d[2:0], d[3]};
		{rd, bwr, wr} <= k;
		@(posedge clk_i);
		{rd, bwr, wr} <= 3'h0;
		#1;
	endtask
	task automatic t_regs();
		op(16'hff7e, 8'h00, 3'h4);
		chk(16'(rdat), 16'h0000);
		op(16'hff94, 8'h00, 3'h4);
		chk(16'(rdat), 16'h0000);
		op(16'hff7e, 8'hff, 3'h1);
		op(16'hff7e, 8'h00, 3'h4);
		chk(16'(rdat), 16'h0087);
		op(16'hff94, 8'h7e, 3'h1);
		op(16'hff94, 8'h08, 3'h2);
		op(16'hff94, 8'h0f, 3'h2);
		op(16'hff94, 8'h00, 3'h4);
		chk(16'(rdat), 16'h0087);
		op(16'hff94, 8'h07, 3'h2);
		op(16'hff94, 8'h00, 3'h4);
		chk(16'(rdat), 16'h0007);
		op(16'hff95, 8'h55, 3'h1);
		op(16'hff95, 8'h00, 3'h4);
		chk(16'(rdat), 16'h0000);
		op(16'hff7e, 8'h07, 3'h2);
		op(16'hff94, 8'h00, 3'h1);
	endtask
	// Runs both timers 256 cycles, counts tick pulses, then stops them
	task automatic run_case(input logic [7:0] a, input logic [7:0] b, input logic [7:0] o,
			input logic [1:0] m, input logic [15:0] e0, input logic [15:0] e1);
		logic [15:0] n0, n1, s0, s1;
		n0 = 16'h0000;
		n1 = 16'h0000;
		@(posedge clk_i);
		osc <= o;
		c1 <= {6'h00, m};
		op(16'hff7e, a, 3'h1);
		op(16'hff94, b, 3'h1);
		repeat (4) @(posedge clk_i);
		#1;
		s0 = cnt0;
		s1 = cnt1;
		repeat (256) begin
			@(posedge clk_i);
			#1;
			n0 += {15'h0000, tk0 === 1'b1};
			n1 += {15'h0000, tk1 === 1'b1};
		end
		chk(n0, e0);
		chk(n1, e1);
		chk(cnt0 - s0, e0);
		chk(cnt1 - s1, e1);
		op(16'hff7e, a & 8'h07, 3'h1);
		op(16'hff94, b & 8'h07, 3'h1);
		@(posedge clk_i);
		#1 chk(cnt0 | cnt1, 16'h0000);
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		t_regs();
		for (int k = 0; k < 8; k++) begin
			run_case({5'h10, k[2:0]}, {5'h10, k[2:0]}, 8'h00, 2'h0, 16'h0100 >> k, 16'h0100 >> k);
		end
		run_case(8'h81, 8'h81, 8'h08, 2'h0, 16'h0100, 16'h0100);
		run_case(8'h80, 8'h80, 8'h08, 2'h0, 16'h0080, 16'h0080);
		run_case(8'h82, 8'h82, 8'h08, 2'h0, 16'h0000, 16'h0000);
		run_case(8'h81, 8'h81, 8'hf7, 2'h0, 16'h0080, 16'h0080);
		run_case(8'h80, 8'h07, 8'h08, 2'h2, 16'h0080, 16'h0080);
		run_case(8'h80, 8'h80, 8'h00, 2'h3, 16'h0100, 16'h0000);
		run_case(8'h00, 8'h80, 8'h00, 2'h1, 16'h0000, 16'h0000);
		run_case(8'h80, 8'h81, 8'h00, 2'h1, 16'h0100, 16'h0080);
		give_verdict();
	end
endmodule
